// ### smi_consts.svh
`ifndef SMI_CONSTS_SVH
`define SMI_CONSTS_SVH

// fixed control code in the upper nibble of the control byte
`define SMI_CTRL_CODE 4'ha
// bits per byte, ninth clock is the acknowledge slot
`define SMI_BYTE_BITS 4'h8
`define SMI_LAST_TX_BIT 4'h7
// sampling clock and highest bus bit rate
`define SMI_REF_CLK_KHZ 100000
`define SMI_MAX_RATE_KBPS 400
`define SMI_BIT_CYCLES (`SMI_REF_CLK_KHZ / `SMI_MAX_RATE_KBPS)
`define SMI_HALF_BIT_CYCLES (`SMI_BIT_CYCLES / 2)
// width of the pin synchroniser: scl, sda, three straps, write protect
`define SMI_SYNC_WIDTH 6

`endif

// ### smi_pkg.sv
package smi_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_rx,
    st_ack,
    st_tx,
    st_mack,
    st_ignore
  } smi_state_e;

  typedef struct packed {
    logic valid;
    logic write_ok;
    logic [7:0] data;
  } smi_rx_s;

  typedef struct packed {
    logic busy;
    logic selected;
    logic read_mode;
    logic write_allowed;
  } smi_status_s;

endpackage : smi_pkg

// ### smi_sync.sv
`timescale 1ns/1ns
`include "smi_consts.svh"

module smi_sync (
  input logic ref_clk,
  input logic resetn,
  input logic [`SMI_SYNC_WIDTH-1:0] pin_in,
  output logic [`SMI_SYNC_WIDTH-1:0] pin_sync
);

  logic [`SMI_SYNC_WIDTH-1:0] meta;
  logic [`SMI_SYNC_WIDTH-1:0] next_meta;
  logic [`SMI_SYNC_WIDTH-1:0] next_sync;

  // idle bus level is all ones; straps and protect settle within two edges
  always_comb begin
    next_meta = pin_in;
    next_sync = meta;
    if (!resetn) begin
      next_meta = {`SMI_SYNC_WIDTH{1'b1}};
      next_sync = {`SMI_SYNC_WIDTH{1'b1}};
    end
  end

  always_ff @(posedge ref_clk) begin
    meta <= next_meta;
    pin_sync <= next_sync;
  end

endmodule : smi_sync

// ### smi_slave.sv
`timescale 1ns/1ns
`include "smi_consts.svh"

module smi_slave (
  input logic ref_clk,
  input logic resetn,
  input logic scl_in,
  input logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input logic chip_select_strap_lsb,
  input logic chip_select_strap_mid,
  input logic chip_select_strap_msb,
  input logic write_protect,
  input logic [7:0] tx_data,
  output logic tx_req,
  output smi_pkg::smi_rx_s rx,
  output smi_pkg::smi_status_s status,
  output logic start_pulse,
  output logic stop_pulse
);

  logic [`SMI_SYNC_WIDTH-1:0] pin_sync;
  logic scl_q;
  logic sda_q;
  logic [2:0] strap_q;
  logic wp_q;
  logic scl_d;
  logic sda_d;
  // edge flops rest at the idle bus level so no false start follows reset
  logic next_scl_d;
  logic next_sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  smi_pkg::smi_state_e state;
  smi_pkg::smi_state_e next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic ctrl_phase;
  logic next_ctrl_phase;
  logic release_sda;
  logic next_release_sda;
  logic next_tx_req;
  logic load_tx;
  smi_pkg::smi_rx_s next_rx;
  smi_pkg::smi_status_s next_status;
  logic next_start_pulse;
  logic next_stop_pulse;

  // pins reach logic only after two flops
  smi_sync u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin_in({write_protect, chip_select_strap_msb, chip_select_strap_mid,
             chip_select_strap_lsb, sda_in, scl_in}),
    .pin_sync(pin_sync)
  );

  assign scl_q = pin_sync[0];
  assign sda_q = pin_sync[1];
  assign strap_q = pin_sync[4:2];
  assign wp_q = pin_sync[5];

  function automatic logic sel_match(input logic [7:0] ctrl, input logic [2:0] strap);
    logic code_ok;
    logic sel_ok;
    code_ok = (ctrl[7:4] == `SMI_CTRL_CODE);
    sel_ok = (ctrl[3:1] == strap);
    return code_ok && sel_ok;
  endfunction : sel_match

  // scl is only sampled, never driven; one 10 ns sample covers 400 kbit/s
  assign scl_rise = scl_q && !scl_d;
  assign scl_fall = !scl_q && scl_d;
  assign start_det = scl_q && scl_d && sda_d && !sda_q;
  assign stop_det = scl_q && scl_d && !sda_d && sda_q;

  // open drain: low level driven, high left to the pull-up
  assign sda_out = 1'b0;
  assign sda_oe_n = release_sda;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_ctrl_phase = ctrl_phase;
    next_release_sda = release_sda;
    next_tx_req = 1'b0;
    next_rx = rx;
    next_rx.valid = 1'b0;
    next_status = status;
    next_status.write_allowed = !wp_q;
    next_start_pulse = start_det;
    next_stop_pulse = stop_det;
    load_tx = 1'b0;
    next_scl_d = scl_q;
    next_sda_d = sda_q;
    if (start_det) begin
      // repeated start drops any byte in flight
      next_state = smi_pkg::st_rx;
      next_cnt = 4'h0;
      next_ctrl_phase = 1'b1;
      next_release_sda = 1'b1;
      next_status.busy = 1'b1;
      next_status.selected = 1'b0;
    end else if (stop_det) begin
      next_state = smi_pkg::st_idle;
      next_cnt = 4'h0;
      next_release_sda = 1'b1;
      next_status.busy = 1'b0;
      next_status.selected = 1'b0;
    end else begin
      unique case (state)
        smi_pkg::st_idle, smi_pkg::st_ignore: begin
          next_release_sda = 1'b1;
        end
        smi_pkg::st_rx: begin
          if (scl_rise && cnt < `SMI_BYTE_BITS) begin
            next_shreg = {shreg[6:0], sda_q};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == `SMI_BYTE_BITS) begin
            if (ctrl_phase) begin
              if (sel_match(shreg, strap_q)) begin
                next_release_sda = 1'b0;
                next_status.selected = 1'b1;
                next_status.read_mode = shreg[0];
                next_state = smi_pkg::st_ack;
              end else begin
                next_state = smi_pkg::st_ignore;
              end
            end else begin
              next_release_sda = 1'b0;
              next_rx.valid = 1'b1;
              next_rx.data = shreg;
              next_rx.write_ok = !wp_q;
              next_state = smi_pkg::st_ack;
            end
          end
        end
        smi_pkg::st_ack: begin
          // ninth falling edge closes the slot
          if (scl_fall) begin
            next_cnt = 4'h0;
            next_ctrl_phase = 1'b0;
            if (status.read_mode) begin
              load_tx = 1'b1;
            end else begin
              next_release_sda = 1'b1;
              next_state = smi_pkg::st_rx;
            end
          end
        end
        smi_pkg::st_tx: begin
          if (scl_fall) begin
            if (cnt == `SMI_LAST_TX_BIT) begin
              next_release_sda = 1'b1;
              next_cnt = 4'h0;
              next_state = smi_pkg::st_mack;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_release_sda = shreg[6];
              next_cnt = cnt + 4'h1;
            end
          end
        end
        smi_pkg::st_mack: begin
          // master nack ends the read; wait for its stop
          if (scl_rise && sda_q) begin
            next_state = smi_pkg::st_ignore;
          end else if (scl_fall) begin
            load_tx = 1'b1;
          end
        end
        default: begin
          // two spare state codes fall back to a quiet bus
          next_state = smi_pkg::st_idle;
        end
      endcase
    end
    if (load_tx) begin
      next_shreg = tx_data;
      next_release_sda = tx_data[7];
      next_tx_req = 1'b1;
      next_cnt = 4'h0;
      next_state = smi_pkg::st_tx;
    end
    if (!resetn) begin
      next_state = smi_pkg::st_idle;
      next_cnt = 4'h0;
      next_shreg = 8'h00;
      next_ctrl_phase = 1'b0;
      next_release_sda = 1'b1;
      next_tx_req = 1'b0;
      next_rx = '0;
      next_status = '0;
      next_start_pulse = 1'b0;
      next_stop_pulse = 1'b0;
      next_scl_d = 1'b1;
      next_sda_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    scl_d <= next_scl_d;
    sda_d <= next_sda_d;
    state <= next_state;
    cnt <= next_cnt;
    shreg <= next_shreg;
    ctrl_phase <= next_ctrl_phase;
    release_sda <= next_release_sda;
    tx_req <= next_tx_req;
    rx <= next_rx;
    status <= next_status;
    start_pulse <= next_start_pulse;
    stop_pulse <= next_stop_pulse;
  end

  // cycles since the last scl edge, for the response-time check
  logic [15:0] gap;
  logic [15:0] next_gap;
  // saturates so a long idle bus cannot wrap into a false pass
  always_comb begin
    next_gap = gap;
    if (!resetn || scl_rise || scl_fall) begin
      next_gap = 16'h0000;
    end else if (gap != 16'hffff) begin
      next_gap = gap + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    gap <= next_gap;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sda_low_change_a: assert property ($fell(release_sda) |-> !scl_q)
    else $error("data line pulled low while clock high");
  start_restart_a: assert property (start_det |=> state == smi_pkg::st_rx && cnt == 4'h0 && ctrl_phase)
    else $error("start did not restart control byte");
  stop_end_a: assert property (stop_det |=> state == smi_pkg::st_idle && !status.busy ##0 release_sda)
    else $error("stop did not end transfer");
  busy_start_a: assert property (start_det |=> status.busy [*2])
    else $error("bus not busy after start");
  eight_bits_a: assert property ($rose(state == smi_pkg::st_ack) |-> $past(cnt) == 4'h8)
    else $error("byte length not eight bits");
  ack_release_a: assert property (state == smi_pkg::st_ack && scl_fall |=> state != smi_pkg::st_ack)
    else $error("acknowledge slot longer than one clock");
  msb_first_a: assert property (tx_req |-> release_sda == $past(tx_data[7]))
    else $error("transmit did not start with msb");
  wp_block_a: assert property (rx.valid && !status.write_allowed |-> !rx.write_ok)
    else $error("write allowed while protected");
  ack_match_a: assert property (state == smi_pkg::st_rx && ctrl_phase && scl_fall && cnt == 4'h8
    && sel_match(shreg, strap_q) |=> !release_sda && status.selected)
    else $error("matching control byte not acknowledged");
  no_ack_miss_a: assert property (state == smi_pkg::st_rx && ctrl_phase && scl_fall && cnt == 4'h8
    && !sel_match(shreg, strap_q) && !start_det && !stop_det
    |=> release_sda && state == smi_pkg::st_ignore)
    else $error("mismatching control byte acknowledged");
  resp_time_a: assert property ($changed(release_sda) && !$past(start_det || stop_det)
    |-> gap < `SMI_HALF_BIT_CYCLES)
    else $error("data line response too slow for bus rate");
  start_flag_a: assert property (start_det |=> start_pulse)
    else $error("start pulse missing");
  stop_flag_a: assert property (stop_det |=> stop_pulse && !status.selected)
    else $error("stop pulse missing or still selected");
  data_ack_a: assert property (state == smi_pkg::st_rx && !ctrl_phase && scl_fall && cnt == 4'h8
    |=> !release_sda && rx.valid && rx.data == $past(shreg))
    else $error("data byte not acknowledged or not handed over");
  read_only_tx_a: assert property (tx_req |-> status.read_mode)
    else $error("transmit requested in write mode");
  write_only_rx_a: assert property (rx.valid |-> !status.read_mode)
    else $error("byte received in read mode");
  ignore_quiet_a: assert property (state == smi_pkg::st_ignore |-> release_sda)
    else $error("data line driven while ignoring bus");
  abort_count_a: assert property (start_det || stop_det |=> cnt == 4'h0)
    else $error("bit counter not cleared by start or stop");
  wp_pass_a: assert property (rx.valid |-> rx.write_ok == status.write_allowed)
    else $error("write permission differs from protect level");

endmodule : smi_slave

// ### smi_bus_master.sv
`timescale 1ns/1ns
module smi_bus_master (
  input logic ref_clk,
  input logic sda_w,
  output logic scl,
  output logic sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : w
  // clock high 8 cycles, low 8: scl period 160 ns
  task automatic start_cond;
    w(4);
    sda_m = 1'b1;
    w(4);
    scl = 1'b1;
    w(8);
    sda_m = 1'b0;
    w(8);
    scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond;
    w(4);
    sda_m = 1'b0;
    w(4);
    scl = 1'b1;
    w(8);
    sda_m = 1'b1;
    w(8);
  endtask : stop_cond
  // data moves mid low phase, never with the clock edge
  task automatic xfer_bit(input logic b, output logic r);
    w(4);
    sda_m = b;
    w(4);
    scl = 1'b1;
    w(8);
    r = sda_w;
    scl = 1'b0;
  endtask : xfer_bit
  task automatic xfer_byte(input logic [7:0] d, input logic a, output logic [7:0] q,
                           output logic ar);
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], q[i]);
    end
    xfer_bit(a, ar);
  endtask : xfer_byte
endmodule : smi_bus_master

// ### tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic wp = 1'b0;
  logic [2:0] strap = 3'b101;
  logic [7:0] tx_data = 8'h3c;
  logic [7:0] q;
  logic scl, sda_m, sda_w, sda_out, sda_oe_n, tx_req, start_pulse, stop_pulse, ack;
  smi_pkg::smi_rx_s rx;
  smi_pkg::smi_status_s status;
  int err_total = 0;
  int num_checks = 0;
  int n_rx = 0;
  int n_req = 0;
  int n0;
  int n_start = 0;
  int n_stop = 0;
  int n_s0;
  int n_p0;
  always #5 ref_clk = ~ref_clk;
  // wired-and with pull-up
  assign sda_w = sda_m & (sda_oe_n | sda_out);
  smi_bus_master m (.ref_clk(ref_clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));
  smi_slave DUT (.ref_clk(ref_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .chip_select_strap_lsb(strap[0]),
    .chip_select_strap_mid(strap[1]), .chip_select_strap_msb(strap[2]),
    .write_protect(wp), .tx_data(tx_data), .tx_req(tx_req), .rx(rx), .status(status),
    .start_pulse(start_pulse), .stop_pulse(stop_pulse));
  always @(posedge ref_clk) begin
    if (rx.valid === 1'b1) n_rx++;
    if (start_pulse === 1'b1) n_start++;
    if (stop_pulse === 1'b1) n_stop++;
    if (tx_req === 1'b1) begin
      n_req++;
      tx_data <= 8'hc3;
    end
  end
  task automatic chk(input logic [15:0] a, input logic [15:0] e);
    num_checks++;
    if (a !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask : chk
  task automatic t_write;
    n_s0 = n_start;
    n_p0 = n_stop;
    m.start_cond();
    chk(status.busy, 1);
    chk(status.write_allowed, 1);
    m.xfer_byte(8'haa, 1'b1, q, ack);
    chk(ack, 0);
    chk(status.read_mode, 0);
    n0 = n_rx;
    m.xfer_byte(8'h5a, 1'b1, q, ack);
    chk(ack, 0);
    chk(rx.data, 8'h5a);
    chk(rx.write_ok, 1);
    m.xfer_byte(8'h81, 1'b1, q, ack);
    chk(rx.data, 8'h81);
    chk(n_rx - n0, 2);
    m.stop_cond();
    chk({status.busy, status.selected}, 0);
    chk(n_start - n_s0, 1);
    chk(n_stop - n_p0, 1);
    $display("test write done");
  endtask : t_write
  task automatic t_protect;
    wp = 1'b1;
    m.start_cond();
    m.xfer_byte(8'haa, 1'b1, q, ack);
    m.xfer_byte(8'h33, 1'b1, q, ack);
    chk(ack, 0);
    chk({rx.write_ok, status.write_allowed}, 0);
    chk(sda_out, 0);
    m.stop_cond();
    wp = 1'b0;
    $display("test protect done");
  endtask : t_protect
  task automatic t_select;
    logic [2:0] s [4] = '{3'b101, 3'b101, 3'b011, 3'b101};
    logic [7:0] c [4] = '{8'ha6, 8'hba, 8'ha6, 8'ha8};
    logic e [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      strap = s[i];
      m.start_cond();
      m.xfer_byte(c[i], 1'b1, q, ack);
      chk(ack, e[i]);
      m.xfer_byte(8'h00, 1'b1, q, ack);
      chk(ack, e[i]);
      chk(status.selected, !e[i]);
      m.stop_cond();
    end
    strap = 3'b101;
    $display("test select done");
  endtask : t_select
  task automatic t_read;
    tx_data = 8'h3c;
    n0 = n_req;
    m.start_cond();
    m.xfer_byte(8'hab, 1'b1, q, ack);
    chk(ack, 0);
    chk(status.read_mode, 1);
    m.xfer_byte(8'hff, 1'b0, q, ack);
    chk(q, 8'h3c);
    m.xfer_byte(8'hff, 1'b1, q, ack);
    chk(q, 8'hc3);
    chk(n_req - n0, 2);
    m.stop_cond();
    $display("test read done");
  endtask : t_read
  task automatic t_abort;
    m.start_cond();
    for (int i = 0; i < 4; i++) m.xfer_bit(1'b1, ack);
    m.start_cond();
    m.xfer_byte(8'haa, 1'b1, q, ack);
    chk(ack, 0);
    m.stop_cond();
    m.start_cond();
    m.xfer_byte(8'haa, 1'b1, q, ack);
    n0 = n_rx;
    for (int i = 0; i < 3; i++) begin
      m.xfer_bit(1'b0, ack);
    end
    m.stop_cond();
    chk({status.busy, status.selected}, 0);
    chk(n_rx - n0, 0);
    $display("test abort done");
  endtask : t_abort
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  initial begin
    #200000;
    err_total++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    chk(sda_oe_n, 1);
    resetn = 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    t_write();
    t_protect();
    t_select();
    t_read();
    t_abort();
    conclude();
  end
endmodule : tb_top
